// ---- design/pdsp_slave.sv ----
// transaction engine of the ddr pseudo-static dram slave port
`timescale 1ns/100ps
module pdsp_slave #(
   parameter int AW = pdsp_pkg::ADDR_W,
   parameter int LAT_CLKS = pdsp_pkg::LAT_CLKS,
   parameter int WRAP_WORDS = pdsp_pkg::WRAP_WORDS,
   parameter int REF_INTERVAL = pdsp_pkg::REF_INTERVAL,
   parameter int REF_BUSY = pdsp_pkg::REF_BUSY
) (
   input wire logic clk_in,              // system clock, 50 MHz
   input wire logic reset_n_in,          // synchronous hardware reset, active low
   input wire logic cs_n_in,             // chip select pin, active low
   input wire logic link_clk_in,         // host clock pin, sampled
   input wire logic [7:0] dq_in,         // data pins, input side
   output logic [7:0] dq_out,            // data pins, output side
   output logic dq_oe_n_out,             // data pins driven when low
   input wire logic rw_strobe_in,        // strobe pin, input side
   output logic rw_strobe_out,           // strobe pin, output side
   output logic rw_strobe_oe_n_out,      // strobe pin driven when low
   output logic refresh_pending_out      // refresh waiting for an idle bus
);
   localparam int BW = pdsp_pkg::BYTE_W;
   localparam int WW = pdsp_pkg::WORD_W;
   localparam int FW = AW + WW + 2;
   localparam int RCW = $clog2(REF_INTERVAL);
   localparam logic [AW-1:0] GMASK = AW'(WRAP_WORDS - 1);
   localparam logic [7:0] LAT_EDGES = 8'(2 * LAT_CLKS);
   localparam logic [7:0] LAT_EDGES_X2 = 8'(4 * LAT_CLKS);

   typedef struct packed {
      pdsp_pkg::pdsp_phase_t phase;
      logic ck_s1;
      logic ck_s2;
      logic ck_d;
      logic cs_s1;
      logic cs_s2;
      logic [7:0] dq_s1;
      logic [7:0] dq_s2;
      logic rw_s1;
      logic rw_s2;
      logic [pdsp_pkg::CMD_BITS-BW-1:0] cmd;
      logic [2:0] edge_cnt;
      logic [7:0] lat_left;
      logic extra;
      logic is_read;
      logic linear;
      logic [AW-1:0] addr;
      logic [7:0] hi;
      logic hmask;
      logic [7:0] lo;
      logic push_valid;
      logic [FW-1:0] push_data;
      logic fetch;
      logic [7:0] dq;
      logic dq_oe_n;
      logic rws;
      logic rws_oe_n;
      logic [RCW-1:0] ref_cnt;
      logic ref_pend;
      logic [7:0] ref_left;
   } pdsp_state_t;

   pdsp_state_t st;
   pdsp_state_t next_st;
   logic rise;
   logic fall;
   logic link_edge;
   logic word_step;
   logic ref_start;
   logic ref_expire;
   logic array_free;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [FW-1:0] fifo_out_data;
   logic wr_go;
   logic rd_go;
   logic mem_en;
   logic [AW-1:0] mem_addr;
   logic [WW-1:0] mem_rdata;
   logic [pdsp_pkg::CMD_BITS-1:0] cmd_full;

   if (AW <= pdsp_pkg::CMD_COL_W || LAT_CLKS < 1 || LAT_CLKS > 63 || REF_BUSY < 1
       || REF_BUSY > 255 || REF_INTERVAL < 2 || WRAP_WORDS < 2
       || (WRAP_WORDS & (WRAP_WORDS - 1)) != 0 || WRAP_WORDS > 2**AW) begin : g_chk
      $error("pdsp_slave parameters out of range");
   end

   function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic lin);
      logic [AW-1:0] inc;
      inc = a + 1'b1;
      // wrapped: only the bits inside the aligned group count
      return lin ? inc : ((a & ~GMASK) | (inc & GMASK));
   endfunction

   // link clock is only sampled; edges are seen two cycles late, data alike
   assign rise = st.ck_s2 & ~st.ck_d;
   assign fall = ~st.ck_s2 & st.ck_d;
   assign link_edge = rise | fall;
   assign word_step = st.is_read ? rise : fall;
   assign cmd_full = {st.cmd, st.dq_s2};

   // refresh waits for an idle bus, so it never stalls a burst
   assign ref_expire = (st.ref_cnt == RCW'(REF_INTERVAL - 1));
   assign ref_start = st.ref_pend & st.cs_s2 & (st.phase == pdsp_pkg::PH_IDLE)
                      & (st.ref_left == '0);
   assign array_free = (st.ref_left == '0);

   // array port: refresh, then queued writes, then read fetches
   assign wr_go = fifo_out_valid & array_free;
   assign rd_go = st.fetch & array_free & ~fifo_out_valid & ~st.push_valid;
   assign mem_en = wr_go | rd_go;
   assign mem_addr = wr_go ? fifo_out_data[FW-1 -: AW] : st.addr;

   assign dq_out = st.dq;
   assign dq_oe_n_out = st.dq_oe_n;
   assign rw_strobe_out = st.rws;
   assign rw_strobe_oe_n_out = st.rws_oe_n;
   assign refresh_pending_out = st.ref_pend;

   pdsp_fifo #(
      .W(FW),
      .DEPTH(pdsp_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .in_valid_in(st.push_valid),
      .in_ready_out(fifo_in_ready),
      .in_data_in(st.push_data),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(array_free),
      .out_data_out(fifo_out_data)
   );

   pdsp_mem #(
      .AW(AW)
   ) u_array (
      .clk_in(clk_in),
      .en_in(mem_en),
      .we_in(wr_go),
      .be_in(fifo_out_data[1:0]),
      .addr_in(mem_addr),
      .wdata_in(fifo_out_data[WW+1:2]),
      .rdata_out(mem_rdata)
   );

   always_comb begin
      next_st = st;
      next_st.ck_s1 = link_clk_in;
      next_st.ck_s2 = st.ck_s1;
      next_st.ck_d = st.ck_s2;
      next_st.cs_s1 = cs_n_in;
      next_st.cs_s2 = st.cs_s1;
      next_st.dq_s1 = dq_in;
      next_st.dq_s2 = st.dq_s1;
      next_st.rw_s1 = rw_strobe_in;
      next_st.rw_s2 = st.rw_s1;

      next_st.ref_cnt = ref_expire ? '0 : st.ref_cnt + 1'b1;
      // a new request wins over the start that clears the old one
      next_st.ref_pend = ref_expire | (st.ref_pend & ~ref_start);
      if (ref_start) begin
         next_st.ref_left = 8'(REF_BUSY);
      end else if (!array_free) begin
         next_st.ref_left = st.ref_left - 1'b1;
      end

      // a word stays offered until the fifo takes it; the next fall overwrites it if not yet taken
      if (st.push_valid && fifo_in_ready) begin
         next_st.push_valid = 1'b0;
      end
      if (rd_go) begin
         next_st.fetch = 1'b0;
      end

      if (st.cs_s2) begin
         next_st.phase = pdsp_pkg::PH_IDLE;
         next_st.dq_oe_n = 1'b1;
         next_st.rws_oe_n = 1'b1;
         next_st.fetch = 1'b0;
      end else begin
         case (st.phase)
            pdsp_pkg::PH_IDLE: begin
               // select seen low with the clock idle; edges follow
               next_st.phase = pdsp_pkg::PH_CMD;
               next_st.edge_cnt = '0;
               next_st.extra = st.ref_pend | ~array_free;
               next_st.rws = st.ref_pend | ~array_free;
               next_st.rws_oe_n = 1'b0;
            end
            pdsp_pkg::PH_CMD: begin
               if (link_edge) begin
                  // one command byte per edge, most significant first
                  next_st.cmd = cmd_full[pdsp_pkg::CMD_BITS-BW-1:0];
                  next_st.edge_cnt = st.edge_cnt + 1'b1;
                  if (st.edge_cnt == 3'(pdsp_pkg::CMD_EDGES - 1)) begin
                     next_st.phase = pdsp_pkg::PH_LAT;
                     next_st.is_read = cmd_full[pdsp_pkg::CMD_RW_BIT];
                     next_st.linear = cmd_full[pdsp_pkg::CMD_LIN_BIT];
                     // word address only: row bits, then word in row
                     next_st.addr = {cmd_full[pdsp_pkg::CMD_ROW_LSB +: AW-pdsp_pkg::CMD_COL_W],
                                     cmd_full[pdsp_pkg::CMD_COL_W-1:0]};
                     next_st.lat_left = st.extra ? LAT_EDGES_X2 : LAT_EDGES;
                     next_st.fetch = cmd_full[pdsp_pkg::CMD_RW_BIT];
                     // reads keep the strobe low until data; writes hand it over
                     next_st.rws = 1'b0;
                     next_st.rws_oe_n = ~cmd_full[pdsp_pkg::CMD_RW_BIT];
                  end
               end
            end
            pdsp_pkg::PH_LAT: begin
               if (link_edge) begin
                  next_st.lat_left = st.lat_left - 1'b1;
                  if (st.lat_left == 8'h01) begin
                     next_st.phase = pdsp_pkg::PH_DATA;
                  end
               end
            end
            pdsp_pkg::PH_DATA: begin
               if (st.is_read) begin
                  if (rise) begin
                     // upper byte on the rising edge, strobe rises with it
                     next_st.dq = mem_rdata[WW-1 -: BW];
                     next_st.lo = mem_rdata[BW-1:0];
                     next_st.dq_oe_n = 1'b0;
                     next_st.rws = 1'b1;
                     next_st.addr = step_addr(st.addr, st.linear);
                     next_st.fetch = 1'b1;
                  end else if (fall) begin
                     next_st.dq = st.lo;
                     next_st.rws = 1'b0;
                  end
               end else begin
                  if (rise) begin
                     next_st.hi = st.dq_s2;
                     next_st.hmask = st.rw_s2;
                  end else if (fall) begin
                     // mask high keeps the byte: enable is its inverse
                     next_st.push_data = {st.addr, st.hi, st.dq_s2, ~st.hmask, ~st.rw_s2};
                     next_st.push_valid = 1'b1;
                     next_st.addr = step_addr(st.addr, st.linear);
                  end
               end
            end
            default: begin
               next_st.phase = pdsp_pkg::PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st <= '0;
         st.cs_s1 <= pdsp_pkg::CS_N_RESET;
         st.cs_s2 <= pdsp_pkg::CS_N_RESET;
         st.dq_oe_n <= pdsp_pkg::OE_N_RESET;
         st.rws_oe_n <= pdsp_pkg::OE_N_RESET;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   a_reset_release_pins: assert property (disable iff (1'b0) !reset_n_in |=>
      dq_oe_n_out && rw_strobe_oe_n_out && st.phase == pdsp_pkg::PH_IDLE)
      else $error("pins not released under reset");

   a_deselect_release: assert property (st.cs_s2 |=>
      dq_oe_n_out && rw_strobe_oe_n_out)
      else $error("pins driven with select high");

   a_cmd_strobe_latency: assert property (st.phase == pdsp_pkg::PH_CMD |->
      !rw_strobe_oe_n_out && rw_strobe_out == st.extra)
      else $error("command phase strobe wrong");

   a_cmd_six_edges: assert property (st.phase == pdsp_pkg::PH_CMD && link_edge
      && st.edge_cnt == 3'h5 && !st.cs_s2 |=> st.phase == pdsp_pkg::PH_LAT
      && st.lat_left == (st.extra ? LAT_EDGES_X2 : LAT_EDGES))
      else $error("command phase length wrong");

   a_lat_to_data: assert property ($rose(st.phase == pdsp_pkg::PH_DATA) |->
      $past(st.lat_left) == 8'h01 && $past(link_edge))
      else $error("data phase started early");

   a_read_strobe_rise: assert property (st.phase == pdsp_pkg::PH_DATA && st.is_read
      && rise && !st.cs_s2 |=> rw_strobe_out && !dq_oe_n_out && dq_out == $past(mem_rdata[15:8]))
      else $error("read strobe or byte missing");

   a_read_strobe_fall: assert property (st.phase == pdsp_pkg::PH_DATA && st.is_read
      && fall && !st.cs_s2 |=> !rw_strobe_out && dq_out == $past(st.lo))
      else $error("read strobe did not fall");

   a_write_mask_map: assert property (st.phase == pdsp_pkg::PH_DATA && !st.is_read
      && fall && !st.cs_s2 |=> st.push_valid && st.push_data[1:0] == {~$past(st.hmask),
      ~$past(st.rw_s2)})
      else $error("write mask mapped wrongly");

   a_wrap_in_group: assert property (st.phase == pdsp_pkg::PH_DATA && !st.linear
      && word_step && !st.cs_s2 |=> (st.addr & ~GMASK) == ($past(st.addr) & ~GMASK)
      && (st.addr & GMASK) == (($past(st.addr) + 1'b1) & GMASK))
      else $error("wrapped burst left its group");

   a_linear_count: assert property (st.phase == pdsp_pkg::PH_DATA && st.linear
      && word_step && !st.cs_s2 |=> st.addr == $past(st.addr) + 1'b1)
      else $error("linear burst skipped a word");

   a_refresh_idle_only: assert property ($rose(st.ref_left != '0) |->
      $past(st.phase) == pdsp_pkg::PH_IDLE && $past(st.cs_s2))
      else $error("refresh began inside a transaction");
endmodule // pdsp_slave

// ---- design/pdsp_pkg.sv ----
// shared constants and types of the pseudo-static dram ddr slave port
package pdsp_pkg;
   // command/address phase: six bytes, one per link clock edge
   localparam int CMD_EDGES = 6;
   localparam int CMD_BITS = 48;
   localparam int CMD_RW_BIT = 47;
   localparam int CMD_LIN_BIT = 45;
   localparam int CMD_ROW_LSB = 16;
   localparam int CMD_COL_W = 3;
   // array word and data-path widths
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 10;
   localparam int WRAP_WORDS = 16;
   localparam int FIFO_DEPTH = 4;
   // timing counts: latency in link clocks, refresh in system clocks
   localparam int LAT_CLKS = 6;
   localparam int REF_INTERVAL = 1000;
   localparam int REF_BUSY = 8;
   // reset levels of the pin drivers and the select sampler: released, deselected
   localparam logic OE_N_RESET = 1'b1;
   localparam logic CS_N_RESET = 1'b1;
   typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_LAT, PH_DATA} pdsp_phase_t;
endpackage

// ---- design/pdsp_fifo.sv ----
// small word fifo with valid/ready on both sides
`timescale 1ns/100ps
module pdsp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = pdsp_pkg::FIFO_DEPTH
) (
   input wire logic clk_in,            // system clock
   input wire logic reset_n_in,        // synchronous reset, active low
   input wire logic in_valid_in,       // writer offers a word
   output logic in_ready_out,          // fifo can take a word
   input wire logic [W-1:0] in_data_in, // word offered
   output logic out_valid_out,         // fifo holds a word
   input wire logic out_ready_in,      // reader takes the word
   output logic [W-1:0] out_data_out   // oldest word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } pdsp_fifo_t;
   pdsp_fifo_t st;
   pdsp_fifo_t next_st;
   logic push;
   logic pop;

   if (DEPTH < 2) begin : g_chk
      $error("fifo depth below two");
   end

   assign in_ready_out = (st.cnt != CW'(DEPTH));
   assign out_valid_out = (st.cnt != '0);
   assign out_data_out = st.mem[st.rp];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = in_data_in;
         next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
      end
      if (pop) begin
         next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
      end
      if (push && !pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (pop && !push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule // pdsp_fifo

// ---- design/pdsp_mem.sv ----
// word array with byte enables and registered read data
`timescale 1ns/100ps
module pdsp_mem #(
   parameter int AW = pdsp_pkg::ADDR_W
) (
   input wire logic clk_in,                          // system clock
   input wire logic en_in,                           // access this cycle
   input wire logic we_in,                           // write when high
   input wire logic [1:0] be_in,                     // byte enables, bit 1 = upper byte
   input wire logic [AW-1:0] addr_in,                // word address
   input wire logic [pdsp_pkg::WORD_W-1:0] wdata_in, // write word
   output logic [pdsp_pkg::WORD_W-1:0] rdata_out     // last word read
);
   localparam int BW = pdsp_pkg::BYTE_W;
   typedef struct packed {
      logic [(2**AW)-1:0][pdsp_pkg::WORD_W-1:0] arr;
      logic [pdsp_pkg::WORD_W-1:0] rdata;
   } pdsp_mem_t;
   pdsp_mem_t st;
   pdsp_mem_t next_st;

   assign rdata_out = st.rdata;

   // array contents carry no reset, as in the real cells
   always_comb begin
      next_st = st;
      if (en_in && we_in) begin
         for (int b = 0; b < 2; b++) begin
            if (be_in[b]) begin
               next_st.arr[addr_in][b*BW +: BW] = wdata_in[b*BW +: BW];
            end
         end
      end else if (en_in) begin
         next_st.rdata = st.arr[addr_in];
      end
   end

   always_ff @(posedge clk_in) begin
      st <= next_st;
   end
endmodule // pdsp_mem

// ---- test/pdsp_host_model.sv ----
// host bus master model for the ddr pseudo-static dram link
`timescale 1ns/100ps
module pdsp_host_model #(
   parameter int LAT_CLKS = pdsp_pkg::LAT_CLKS
) (
   input wire logic clk_in,             // system clock, paces the link
   output logic cs_n_out,               // chip select, active low
   output logic link_clk_out,           // link clock, idle low
   output logic [7:0] dq_out,           // resolved data pins
   output logic rw_strobe_out,          // resolved strobe pin
   input wire logic [7:0] dev_dq_in,    // device data byte
   input wire logic dev_dq_oe_n_in,     // device drives data when low
   input wire logic dev_strobe_in,      // device strobe value
   input wire logic dev_strobe_oe_n_in, // device drives strobe when low
   output logic clash_out               // both parties drove one pin
);
   logic [7:0] h_dq;
   logic [7:0] dq_last;
   logic h_dq_en;
   logic h_st;
   logic h_st_en;
   logic st_last;
   int hp;
   // no pull on these lines: a released pin shows the inverse of its last level
   assign dq_out = h_dq_en ? h_dq : (!dev_dq_oe_n_in ? dev_dq_in : ~dq_last);
   assign rw_strobe_out = h_st_en ? h_st : (!dev_strobe_oe_n_in ? dev_strobe_in : ~st_last);
   initial begin
      hp = 4;
      cs_n_out = 1'b1;
      link_clk_out = 1'b0;
      {h_dq, h_dq_en, h_st, h_st_en, dq_last, st_last, clash_out} = '0;
   end
   always @(posedge clk_in) begin
      dq_last <= dq_out;
      st_last <= rw_strobe_out;
      if ((h_dq_en && !dev_dq_oe_n_in) || (h_st_en && !dev_strobe_oe_n_in)) begin
         clash_out <= 1'b1;
      end
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // byte set a quarter link clock period before its edge and held a quarter period after
   task automatic put_edge(input logic [7:0] b, input logic en_st, input logic st);
      h_dq = b;
      h_dq_en = 1'b1;
      h_st = st;
      h_st_en = en_st;
      wait_clk(hp / 2);
      link_clk_out = ~link_clk_out;
      wait_clk(hp - hp / 2);
   endtask
   task automatic get_edge(input logic lvl, output logic [7:0] b, inout logic ok);
      h_dq_en = 1'b0;
      h_st_en = 1'b0;
      link_clk_out = ~link_clk_out;
      wait_clk(hp);
      b = dev_dq_in;
      if (dev_dq_oe_n_in !== 1'b0 || dev_strobe_oe_n_in !== 1'b0 || dev_strobe_in !== lvl) begin
         ok = 1'b0;
      end
   endtask
   task automatic xfer(input logic rd, input logic lin, input logic [9:0] a, input int n,
         input logic [15:0] wd[128], input logic [1:0] wm[128],
         output logic [15:0] rdat[128], output logic flag, output logic ok);
      logic [47:0] cmd;
      logic [7:0] hi;
      logic [7:0] lo;
      ok = 1'b1;
      cmd = '0;
      cmd[pdsp_pkg::CMD_RW_BIT] = rd;
      cmd[pdsp_pkg::CMD_LIN_BIT] = lin;
      cmd[pdsp_pkg::CMD_ROW_LSB +: 7] = a[9:3];
      cmd[2:0] = a[2:0];
      cs_n_out = 1'b0;
      wait_clk(2);
      for (int e = 0; e < 6; e++) begin
         put_edge(cmd[47 - 8 * e -: 8], 1'b0, 1'b0);
         if (e == 2) begin
            if (dev_strobe_oe_n_in !== 1'b0) ok = 1'b0;
            flag = dev_strobe_in;
         end
      end
      h_dq_en = 1'b0;
      repeat ((flag ? 4 : 2) * LAT_CLKS) begin
         wait_clk(hp / 2);
         link_clk_out = ~link_clk_out;
         wait_clk(hp - hp / 2);
      end
      for (int w = 0; w < n; w++) begin
         if (rd) begin
            get_edge(1'b1, hi, ok);
            get_edge(1'b0, lo, ok);
            rdat[w] = {hi, lo};
         end else begin
            put_edge(wd[w][15:8], 1'b1, wm[w][1]);
            put_edge(wd[w][7:0], 1'b1, wm[w][0]);
         end
      end
      h_dq_en = 1'b0;
      h_st_en = 1'b0;
      cs_n_out = 1'b1;
      wait_clk(4);
      if (dev_dq_oe_n_in !== 1'b1 || dev_strobe_oe_n_in !== 1'b1) ok = 1'b0;
   endtask
   task automatic stray(output logic ok);
      ok = 1'b1;
      repeat (4) begin
         wait_clk(hp);
         link_clk_out = ~link_clk_out;
         if (dev_dq_oe_n_in !== 1'b1 || dev_strobe_oe_n_in !== 1'b1) ok = 1'b0;
      end
   endtask
endmodule // pdsp_host_model

// ---- test/testbench.sv ----
// self-checking bench for the ddr pseudo-static dram slave port
`timescale 1ns/100ps
module testbench;
   localparam int LAT = 2;
   logic clk_in, reset_n_in, cs_n, lclk, st, st_o, st_oe_n, dq_oe_n, pend, flag, ok, clash;
   logic [7:0] dq, dq_o;
   logic [15:0] shadow[1024];
   logic [1:0] known[1024];
   logic [15:0] wd[128], rdat[128];
   logic [1:0] wm[128];
   logic [9:0] ra;
   logic [31:0] seed = 32'h17ae_6189;
   int err_count = 0;
   int samples_checked = 0;
   // refresh kept long so a transaction right after a burst surely sees it
   pdsp_slave #(.LAT_CLKS(LAT), .REF_INTERVAL(200), .REF_BUSY(40)) u_pdsp_slave (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n), .link_clk_in(lclk),
      .dq_in(dq), .dq_out(dq_o), .dq_oe_n_out(dq_oe_n), .rw_strobe_in(st),
      .rw_strobe_out(st_o), .rw_strobe_oe_n_out(st_oe_n), .refresh_pending_out(pend));
   pdsp_host_model #(.LAT_CLKS(LAT)) u_pdsp_host_model (
      .clk_in(clk_in), .cs_n_out(cs_n), .link_clk_out(lclk), .dq_out(dq),
      .rw_strobe_out(st), .dev_dq_in(dq_o), .dev_dq_oe_n_in(dq_oe_n),
      .dev_strobe_in(st_o), .dev_strobe_oe_n_in(st_oe_n), .clash_out(clash));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [9:0] step(input logic [9:0] a, input logic lin);
      return lin ? a + 10'h001 : {a[9:4], a[3:0] + 4'h1};
   endfunction
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp, input string what);
      check_word({15'h0000, got}, {15'h0000, exp}, what);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic fill(input logic masked);
      for (int i = 0; i < 128; i++) begin
         wd[i] = 16'(rnd());
         wm[i] = masked ? 2'(rnd()) & 2'(rnd()) : 2'b00;
      end
   endtask
   task automatic run(input logic rd, input logic lin, input logic [9:0] a0, input int n);
      logic [9:0] a;
      logic p;
      a = a0;
      p = pend;
      u_pdsp_host_model.xfer(rd, lin, a0, n, wd, wm, rdat, flag, ok);
      check_bit(ok, 1'b1, "link timing");
      if (p === 1'b1) check_bit(flag, 1'b1, "refresh flag");
      for (int w = 0; w < n; w++) begin
         for (int b = 0; b < 2; b++) begin
            if (rd && known[a][b]) begin
               check_word({8'h00, rdat[w][8 * b +: 8]}, {8'h00, shadow[a][8 * b +: 8]}, "read");
            end
            if (!rd && !wm[w][b]) begin
               shadow[a][8 * b +: 8] = wd[w][8 * b +: 8];
               known[a][b] = 1'b1;
            end
         end
         a = step(a, lin);
      end
   endtask
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      repeat (100000) @(posedge clk_in);
      err_count++;
      $display("ERROR %0t run did not finish", $time);
      close_out();
   end
   initial begin
      reset_n_in = 1'b0;
      foreach (known[i]) known[i] = 2'b00;
      repeat (8) @(negedge clk_in);
      check_bit(dq_oe_n & st_oe_n, 1'b1, "pins released in reset");
      reset_n_in = 1'b1;
      repeat (3) @(negedge clk_in);
      fill(1'b0);
      run(1'b0, 1'b1, 10'h000, 16);
      check_bit(flag, 1'b0, "no refresh wait");
      run(1'b1, 1'b0, 10'h00e, 18);
      run(1'b1, 1'b1, 10'h006, 4);
      run(1'b0, 1'b1, 10'h100, 100);
      run(1'b1, 1'b1, 10'h100, 8);
      check_bit(flag, 1'b1, "refresh wait after long burst");
      u_pdsp_host_model.stray(ok);
      check_bit(ok, 1'b1, "edges with select high");
      reset_n_in = 1'b0;
      repeat (3) @(negedge clk_in);
      check_bit(dq_oe_n & st_oe_n, 1'b1, "pins released in reset");
      check_bit(pend, 1'b0, "no refresh pending in reset");
      reset_n_in = 1'b1;
      repeat (3) @(negedge clk_in);
      run(1'b1, 1'b1, 10'h000, 4);
      for (int i = 0; i < 30; i++) begin
         ra = 10'(rnd() % 900);
         fill(1'b1);
         run(1'b0, 1'(rnd()), ra, 1 + rnd() % 20);
         run(1'b1, 1'(rnd()), ra, 1 + rnd() % 20);
      end
      check_bit(clash, 1'b0, "pin drive clash");
      close_out();
   end
endmodule // testbench
